// ==== i2cpg_defs.vh ====
/*
  constants of the two-wire page access slave: byte layout, row size,
  programming interval and the internal location space.
  assumes inclusion by the slave design files only.
*/
`ifndef I2CPG_DEFS_VH
`define I2CPG_DEFS_VH

`define I2CPG_CLK_MHZ 250
`define I2CPG_NV_PROG_US 10
`define I2CPG_NV_PROG_CYC (`I2CPG_NV_PROG_US * `I2CPG_CLK_MHZ)
`define I2CPG_ROW_BYTES 8
`define I2CPG_ROW_BITS 3
`define I2CPG_LOC_BITS 8
`define I2CPG_MEM_WORDS 256
`define I2CPG_DEV_ADDR 7'h50
`define I2CPG_BIT_LAST 4'h7
`define I2CPG_BIT_ACK 4'h8
`define I2CPG_RW_BIT 0

`endif

// ==== i2cpg_sync.v ====
/*
  two-flip-flop synchroniser for the bus wires.
  assumes inputs come from outside the i_mclk domain.
*/
`timescale 1ns/1ps
module i2cpg_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_async,
  output reg o_sync
);
  reg stage1;

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      stage1 <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // i2cpg_sync

// ==== i2cpg_slave.v ====
/*
  two-wire slave with paged nonvolatile memory: byte and row writes,
  row wrap, programming busy period, current, random and sequential reads.
  assumes scl and sda arrive asynchronously; sda is open drain, pulled up.
*/
`timescale 1ns/1ps
`include "i2cpg_defs.vh"
module i2cpg_slave #(
  parameter LOC_BITS = `I2CPG_LOC_BITS,
  parameter MEM_WORDS = `I2CPG_MEM_WORDS,
  parameter [6:0] DEV_ADDR = `I2CPG_DEV_ADDR, // arbitrary value
  parameter PROG_CYC = `I2CPG_NV_PROG_CYC
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe,
  output reg o_nv_busy,
  output reg o_nv_commit,
  output reg [LOC_BITS-1:0] o_nv_row_base
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_LOC = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_RACK = 3'h5;

  //////////////////////////////////////////////////////////////////////
  // pin sampling and bus condition detection

  wire scl_s;
  wire sda_s;
  reg scl_d;
  reg sda_d;

  i2cpg_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_scl),
    .o_sync(scl_s)
  );

  i2cpg_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_sda),
    .o_sync(sda_s)
  );

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  //////////////////////////////////////////////////////////////////////
  // helpers

  // next location inside the same row
  function [LOC_BITS-1:0] row_next;
    input [LOC_BITS-1:0] loc;
    begin
      row_next = {loc[LOC_BITS-1:`I2CPG_ROW_BITS],
                  loc[`I2CPG_ROW_BITS-1:0] + 3'h1};
    end
  endfunction

  // base location of the row holding loc
  function [LOC_BITS-1:0] row_base;
    input [LOC_BITS-1:0] loc;
    begin
      row_base = {loc[LOC_BITS-1:`I2CPG_ROW_BITS], 3'h0};
    end
  endfunction

  // next location across the whole space, for reads
  function [LOC_BITS-1:0] loc_step;
    input [LOC_BITS-1:0] loc;
    begin
      loc_step = loc + 1'b1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // memory and state

  reg [7:0] mem [0:MEM_WORDS-1];
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [LOC_BITS-1:0] loc_cnt;
  reg wrote_data;
  reg [31:0] prog_cnt;
  reg in_ack;
  reg [31:0] next_prog_cnt;
  reg next_busy;
  reg next_commit;
  reg [2:0] next_state;
  reg next_ack;

  wire addr_hit = (shift[7:1] == DEV_ADDR);
  wire active = (state != ST_IDLE);
  wire tx_phase = (state == ST_RDATA) && !in_ack;
  wire rx_sample = active && scl_rise && !in_ack && !tx_phase;
  wire master_answer = active && scl_rise && in_ack && (state == ST_RACK);
  wire byte_end = (bit_cnt == `I2CPG_BIT_ACK);
  wire rx_byte_end = active && scl_fall && !in_ack && !tx_phase && byte_end;
  wire prog_start = stop_det && wrote_data;
  wire mem_we = rx_byte_end && (state == ST_WDATA);
  wire [7:0] tx_byte = mem[loc_cnt];

  //////////////////////////////////////////////////////////////////////
  // programming interval timer

  always @* begin
    next_prog_cnt = prog_cnt;
    next_busy = o_nv_busy;
    next_commit = 1'b0;
    if (prog_start) begin
      next_busy = 1'b1;
      next_prog_cnt = PROG_CYC;
    end else if (o_nv_busy) begin
      next_prog_cnt = prog_cnt - 32'h1;
      if (prog_cnt == 32'h1) begin
        next_busy = 1'b0;
        next_commit = 1'b1;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prog_cnt <= 32'h0;
      o_nv_busy <= 1'b0;
      o_nv_commit <= 1'b0;
      o_nv_row_base <= {LOC_BITS{1'b0}};
    end else begin
      prog_cnt <= next_prog_cnt;
      o_nv_busy <= next_busy;
      o_nv_commit <= next_commit;
      if (prog_start) begin
        o_nv_row_base <= row_base(loc_cnt);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // row storage, written when a data byte ends

  always @(posedge i_mclk) begin
    if (mem_we) begin
      mem[loc_cnt] <= shift;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sda drive value, always low when enabled

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sda <= 1'b1;
    end else begin
      o_sda <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decision after the eighth bit of a received byte

  always @* begin
    next_state = ST_IDLE;
    next_ack = 1'b0;
    case (state)
      ST_ADDR: begin
        if (addr_hit && !o_nv_busy) begin
          next_ack = 1'b1;
          next_state = shift[`I2CPG_RW_BIT] ? ST_RDATA : ST_LOC;
        end
      end
      ST_LOC: begin
        next_ack = 1'b1;
        next_state = ST_WDATA;
      end
      ST_WDATA: begin
        next_ack = 1'b1;
        next_state = ST_WDATA;
      end
      default: begin
        next_ack = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // bus transaction sequencer

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      loc_cnt <= {LOC_BITS{1'b0}};
      wrote_data <= 1'b0;
      in_ack <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (start_det) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      in_ack <= 1'b0;
      o_sda_oe <= 1'b0;
      wrote_data <= 1'b0;
    end else if (rx_sample) begin
      shift <= {shift[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (master_answer) begin
      // master answer to a read byte
      if (sda_s) begin
        state <= ST_IDLE;
      end else begin
        state <= ST_RDATA;
      end
    end else if (active && scl_fall && in_ack) begin
      // end of an acknowledge bit
      in_ack <= 1'b0;
      bit_cnt <= 4'h0;
      o_sda_oe <= 1'b0;
      if (state == ST_RDATA) begin
        o_sda_oe <= ~tx_byte[7];
        shift <= {tx_byte[6:0], 1'b0};
        bit_cnt <= 4'h1;
      end
    end else if (tx_phase && scl_fall) begin
      if (byte_end) begin
        o_sda_oe <= 1'b0; // release for master answer
        loc_cnt <= loc_step(loc_cnt);
        state <= ST_RACK;
        in_ack <= 1'b1;
      end else begin
        o_sda_oe <= ~shift[7];
        shift <= {shift[6:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (rx_byte_end) begin
      in_ack <= next_ack;
      state <= next_state;
      o_sda_oe <= next_ack;
      if (state == ST_LOC) begin
        loc_cnt <= shift[LOC_BITS-1:0];
      end
      if (state == ST_WDATA) begin
        loc_cnt <= row_next(loc_cnt);
        wrote_data <= 1'b1;
      end
    end
  end

endmodule // i2cpg_slave

// ==== i2cpg_checker_properties.sv ====
/* checker of the slave's bus and programming outputs.
   assumes bind to i2cpg_slave, scl and sda idle high. */
`timescale 1ns/1ps
module i2cpg_checker #(
  parameter PROG_CYC = 20
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda,
  input wire o_sda_oe,
  input wire o_nv_busy,
  input wire o_nv_commit,
  input wire [7:0] o_nv_row_base
);
  int busy_cnt;
  always @(posedge i_mclk) busy_cnt <= (!i_rst_n || !o_nv_busy) ? 0 : busy_cnt + 1;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_pulse; o_nv_commit ##1 !o_nv_commit; endsequence
  a_commit_pulse: assert property ($rose(o_nv_commit) |-> s_pulse)
    else $error("commit not one cycle");
  a_commit_after: assert property (o_nv_commit |-> $past(o_nv_busy))
    else $error("commit without busy");
  a_busy_len: assert property ($fell(o_nv_busy) |-> busy_cnt == PROG_CYC)
    else $error("busy length wrong");
  a_no_ack_busy: assert property (o_nv_busy && $past(o_nv_busy, 4) |-> !o_sda_oe)
    else $error("drive while busy");
  a_drive_low: assert property (o_sda_oe |-> !o_sda)
    else $error("drive not low");
  a_base_stable: assert property (o_nv_busy && $past(o_nv_busy) |-> $stable(o_nv_row_base))
    else $error("row base moved");
  a_row_align: assert property (o_nv_busy |-> o_nv_row_base[2:0] == 3'h0)
    else $error("row base unaligned");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("sda moved with scl high");
  a_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe[*5])
    else $error("drive too short");
  a_busy_idle: assert property ($rose(o_nv_busy) |-> i_scl && i_sda)
    else $error("busy not after stop");
endmodule // i2cpg_checker
bind i2cpg_slave i2cpg_checker #(.PROG_CYC(PROG_CYC)) u_i2cpg_checker (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_nv_busy(o_nv_busy), .o_nv_commit(o_nv_commit), .o_nv_row_base(o_nv_row_base));

// ==== i2cpg_master.sv ====
/* two-wire bus master model, scl period 48 ns.
   assumes sda resolved outside with a pull-up. */
`timescale 1ns/1ps
module i2cpg_master (
  input wire i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // one bit, msb first order set by callers
  task bit_x(input logic b, output logic r);
    #16 o_sda_low = !b;
    #16 o_scl = 1'b1;
    r = i_sda;
    #16 o_scl = 1'b0;
  endtask
  task start;
    #16.5 o_sda_low = 1'b0;
    #16 o_scl = 1'b1;
    #16 o_sda_low = 1'b1;
    #16 o_scl = 1'b0;
  endtask
  task stop;
    #16 o_sda_low = 1'b1;
    #16 o_scl = 1'b1;
    #16 o_sda_low = 1'b0;
    #32;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask
endmodule // i2cpg_master

// ==== i2c_slave_page_access_bench.sv ====
/* self-checking bench of the page access slave.
   assumes i2cpg_master drives the bus, checker bound. */
`timescale 1ns/1ps
`define chk(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module i2c_slave_page_access_bench;
  localparam logic [6:0] DADR = 7'h2C; // arbitrary value
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  wire scl, sda_low, oe, drv, busy, commit;
  wire [7:0] base;
  wire sda = !(oe || sda_low);
  int error_cnt, comparisons, n, commits;
  logic a;
  logic [7:0] tl [4] = '{8'h00, 8'h09, 8'h10, 8'hFF};
  logic [7:0] td [4] = '{8'h5A, 8'hC3, 8'h81, 8'h3E};
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (commit) commits++;
  i2cpg_slave #(.DEV_ADDR(DADR), .PROG_CYC(400)) u_i2cpg_slave (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda(drv), .o_sda_oe(oe),
    .o_nv_busy(busy), .o_nv_commit(commit), .o_nv_row_base(base));
  i2cpg_master u_i2cpg_master (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task addr(input logic rw);
    logic k;
    u_i2cpg_master.start();
    u_i2cpg_master.wbyte({DADR, rw}, k);
    `chk("addr ack", 1'b1, k)
  endtask
  task wr(input logic [7:0] loc, input logic [23:0] d, input int c);
    logic k;
    addr(1'b0);
    u_i2cpg_master.wbyte(loc, k);
    `chk("loc ack", 1'b1, k)
    for (int i = 0; i < c; i++) begin
      u_i2cpg_master.wbyte(d[23-8*i -: 8], k);
      `chk("data ack", 1'b1, k)
    end
    u_i2cpg_master.stop();
  endtask
  task rd(input logic [7:0] loc, input logic dummy, input int c, input logic [15:0] e);
    logic [7:0] q;
    logic k;
    if (dummy) begin
      addr(1'b0);
      u_i2cpg_master.wbyte(loc, k);
    end
    addr(1'b1);
    for (int i = 0; i < c; i++) begin
      u_i2cpg_master.rbyte(i < c - 1, q);
      `chk("read", e[15-8*i -: 8], q)
    end
    u_i2cpg_master.stop();
  endtask
  task poll(output int naks);
    logic k;
    naks = 0;
    repeat (50) begin
      u_i2cpg_master.start();
      u_i2cpg_master.wbyte({DADR, 1'b0}, k);
      u_i2cpg_master.stop();
      if (k) break;
      naks++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 `chk("oe", 1'b0, oe) // reset
    `chk("busy", 1'b0, busy) // reset
    `chk("base", 8'h00, base) // reset
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    for (int i = 0; i < 4; i++) begin
      wr(tl[i], {td[i], 16'h0}, 1);
      poll(n);
      rd(tl[i], 1'b1, 1, {td[i], 8'h00});
    end
    wr(8'h0E, 24'hA1B2C7, 3);
    `chk("busy", 1'b1, busy)
    `chk("row", 8'h08, base)
    poll(n);
    `chk("naks", 1'b1, n > 0)
    rd(8'h08, 1'b1, 1, 16'hC700);
    rd(8'h09, 1'b1, 1, {td[1], 8'h00});
    rd(8'h0E, 1'b1, 2, 16'hA1B2);
    rd(8'h00, 1'b0, 1, {td[2], 8'h00});
    rd(8'hFF, 1'b1, 2, {td[3], td[0]});
    u_i2cpg_master.start();
    u_i2cpg_master.wbyte({DADR ^ 7'h01, 1'b0}, a);
    `chk("wrong addr", 1'b0, a)
    u_i2cpg_master.wbyte(8'h00, a);
    `chk("ignored", 1'b0, a)
    u_i2cpg_master.stop();
    wr(8'h20, 24'h0, 0);
    `chk("dummy busy", 1'b0, busy)
    `chk("commits", 5, commits)
    test_done();
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule // i2c_slave_page_access_bench
